/* File: hw/sfdpe_pkg.sv */
// Constants shared by the serial flash dummy-clock and page-erase logic
package sfdpe_pkg;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_PAGE_ERASE_A = 8'h81;
    localparam logic [7:0] OP_PAGE_ERASE_B = 8'hDB;
    localparam logic [7:0] OP_STATUS_IRQ = 8'h25;
    localparam logic [7:0] OP_XIP_READ = 8'hEB;
    localparam logic [7:0] OP_XIP_READ_ALIGNED = 8'hE7;
    localparam int CNT_W = 6;
    localparam logic [5:0] BITS_CMD = 6'h08;
    localparam logic [5:0] BITS_ERASE_FRAME = 6'h20;
    localparam logic [5:0] BITS_SAT = 6'h28;
    localparam int ADDR_W = 24;
    localparam int PAGE_W = 11;
    localparam int PAGE_LSB = 8;
    localparam int PAGE_MSB = 18;
    localparam int SET_W = 3;
    localparam logic [2:0] DC_MAX_SETTING = 3'h4;
    localparam logic [3:0] DC_BASE_CLOCKS = 4'h2;
    localparam logic [3:0] DC_MAX_CLOCKS = 4'hA;
    localparam logic [3:0] MODE_CLOCKS = 4'h2;
    localparam logic [4:0] XIP_CMD_CLOCKS = 5'h08;
    localparam logic [4:0] XIP_ADDR_CLOCKS = 5'h06;
    localparam int REF_CLK_PERIOD_NS = 25;
    localparam int PAGE_ERASE_TIME_US_DEFAULT = 1000;
endpackage

/* File: hw/sfdpe_core.sv */
// Serial flash command logic: quad read dummy clocks and page erase
//
// Summary of operation
// - The quad read dummy count is 2, 4, 6, 8 or 10 clocks for setting 000 to 100.
// - The two clocks that carry the mode byte are part of the dummy count, not added to it.
// - The EBh read uses aligned or unaligned addresses as the alignment select bit says.
// - The E7h read always uses aligned addresses and ignores the alignment select bit.
// - Page erase is 8 opcode bits then 24 address bits on the serial input, MSB first, no data.
// - Address bits 18 to 8 give the page index; bits 23 to 19 and 7 to 0 are ignored.
// - Chip select rising after a valid page erase starts a self-timed erase of that page.
// - The busy flag stays set for the whole erase and clears when it completes.
// - The write latch is cleared before the erase finishes.
// - After 25h the busy flag is driven on the serial output and refreshed every clock.
// - Chip select rising off a byte boundary aborts the erase with no action.
// - Chip select rising before all three address bytes aborts the erase.
`timescale 1ns/1ps

module sfdpe_core #(
    parameter int PageEraseTimeUs = sfdpe_pkg::PAGE_ERASE_TIME_US_DEFAULT,
    parameter int PageEraseCycles = (PageEraseTimeUs * 1000) / sfdpe_pkg::REF_CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic linkSck,
    input wire logic csN,
    input wire logic si,
    output logic so,
    output logic soOe,
    input wire logic [sfdpe_pkg::SET_W-1:0] dummyCycleSetting,
    input wire logic dwordAlignSelect,
    output logic [3:0] xipDummyClocks,
    output logic [4:0] xipDataStartClock,
    output logic xipAlignedAddr,
    output logic writeLatchFlag,
    output logic operationInProgressFlag,
    output logic [sfdpe_pkg::PAGE_W-1:0] erasePageIndex,
    output logic eraseStart,
    output logic eraseDone,
    output logic eraseRejected
);
    localparam int TMR_W = $clog2(PageEraseCycles + 1);

    // Refuse settings that the timer, the counters or the decoders cannot serve
    if (PageEraseTimeUs < 1) begin
        $error("PageEraseTimeUs must be at least one");
    end
    if (PageEraseCycles < 1) begin
        $error("PageEraseCycles must be at least one");
    end
    if (TMR_W > 32) begin
        $error("Erase timer wider than an int");
    end
    if (sfdpe_pkg::SET_W != 3) begin
        $error("Dummy setting field must be three bits");
    end
    if (sfdpe_pkg::PAGE_MSB - sfdpe_pkg::PAGE_LSB + 1 != sfdpe_pkg::PAGE_W) begin
        $error("Page index bounds do not match its width");
    end
    if (sfdpe_pkg::PAGE_MSB >= sfdpe_pkg::ADDR_W) begin
        $error("Page index lies outside the address");
    end
    if (sfdpe_pkg::BITS_ERASE_FRAME[2:0] != 3'h0) begin
        $error("Erase frame must be whole bytes");
    end
    if (sfdpe_pkg::BITS_SAT <= sfdpe_pkg::BITS_ERASE_FRAME) begin
        $error("Bit counter must saturate above the erase frame");
    end
    if (int'(sfdpe_pkg::BITS_SAT) > (1 << sfdpe_pkg::CNT_W) - 1) begin
        $error("Bit counter too narrow for its saturation value");
    end

    // ---------------- Link domain ----------------
    logic newFrame_q;
    logic asiActive_q, asiActive_d;
    logic [sfdpe_pkg::CNT_W-1:0] bitCnt_q, bitCnt_d;
    logic [sfdpe_pkg::ADDR_W-1:0] shift_q, shift_d;
    logic [7:0] opcode_q, opcode_d;
    logic [sfdpe_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [2:0] busyLink_q;
    logic busyLinkStable_q, busyLinkStable_d;
    logic so_q, so_d;

    // Marks the first clock of each frame; chip select high rearms it
    always_ff @(posedge linkSck or posedge csN or negedge reset_n) begin
        if (!reset_n) begin
            newFrame_q <= 1'b1;
        end else if (csN) begin
            newFrame_q <= 1'b1;
        end else begin
            newFrame_q <= 1'b0;
        end
    end

    // Frame shifter; totals survive chip select so the core can judge the frame
    always_comb begin
        shift_d = {shift_q[sfdpe_pkg::ADDR_W-2:0], si};
        opcode_d = opcode_q;
        addr_d = addr_q;
        if (newFrame_q) begin
            bitCnt_d = 6'h01;
        end else if (bitCnt_q == sfdpe_pkg::BITS_SAT) begin
            bitCnt_d = bitCnt_q;
        end else begin
            bitCnt_d = bitCnt_q + 6'h01;
        end
        if (bitCnt_d == sfdpe_pkg::BITS_CMD) begin
            opcode_d = shift_d[7:0];
        end
        if (bitCnt_d == sfdpe_pkg::BITS_ERASE_FRAME) begin
            addr_d = shift_d;
        end
        asiActive_d = asiActive_q;
        if (bitCnt_d == sfdpe_pkg::BITS_CMD && shift_d[7:0] == sfdpe_pkg::OP_STATUS_IRQ) begin
            asiActive_d = 1'b1;
        end
        if (busyLink_q[1] == busyLink_q[2]) begin
            busyLinkStable_d = busyLink_q[2];
        end else begin
            busyLinkStable_d = busyLinkStable_q;
        end
        so_d = busyLinkStable_d;
    end

    always_ff @(posedge linkSck or negedge reset_n) begin
        if (!reset_n) begin
            bitCnt_q <= 6'h00;
            shift_q <= 24'h00_0000;
            opcode_q <= 8'h00;
            addr_q <= 24'h00_0000;
            busyLink_q <= 3'h0;
            busyLinkStable_q <= 1'b0;
            so_q <= 1'b0;
        end else begin
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            opcode_q <= opcode_d;
            addr_q <= addr_d;
            busyLink_q <= {busyLink_q[1:0], operationInProgressFlag};
            busyLinkStable_q <= busyLinkStable_d;
            so_q <= so_d;
        end
    end

    // Status drive lasts until chip select rises
    always_ff @(posedge linkSck or posedge csN or negedge reset_n) begin
        if (!reset_n) begin
            asiActive_q <= 1'b0;
        end else if (csN) begin
            asiActive_q <= 1'b0;
        end else begin
            asiActive_q <= asiActive_d;
        end
    end

    assign so = so_q;
    assign soOe = asiActive_q;

    // ---------------- Core domain ----------------
    typedef enum logic [0:0] {SFDPE_IDLE, SFDPE_ERASING} sfdpe_state_t;

    sfdpe_state_t state_q, state_d;
    logic [2:0] csSync_q;
    logic csStable_q, csStable_d;
    logic wel_q, wel_d;
    logic [TMR_W-1:0] timer_q, timer_d;
    logic [sfdpe_pkg::PAGE_W-1:0] page_q, page_d;
    logic start_q, start_d;
    logic done_q, done_d;
    logic reject_q, reject_d;
    logic csRise;
    logic frameWhole;
    logic isErase;

    assign csRise = !csStable_q && csSync_q[1] && csSync_q[2];
    // Link frame totals are still because the link clock stops outside frames
    assign frameWhole = (bitCnt_q[2:0] == 3'h0);
    assign isErase = (opcode_q == sfdpe_pkg::OP_PAGE_ERASE_A) ||
                     (opcode_q == sfdpe_pkg::OP_PAGE_ERASE_B);

    always_comb begin
        state_d = state_q;
        wel_d = wel_q;
        timer_d = timer_q;
        page_d = page_q;
        start_d = 1'b0;
        done_d = 1'b0;
        reject_d = 1'b0;
        csStable_d = csStable_q;
        if (csSync_q[1] == csSync_q[2]) begin
            csStable_d = csSync_q[2];
        end
        unique case (state_q)
            SFDPE_IDLE: begin
                if (csRise && frameWhole && bitCnt_q == sfdpe_pkg::BITS_CMD &&
                    opcode_q == sfdpe_pkg::OP_WRITE_ENABLE) begin
                    wel_d = 1'b1;
                end
                if (csRise && isErase && bitCnt_q >= sfdpe_pkg::BITS_CMD) begin
                    if (!frameWhole || bitCnt_q != sfdpe_pkg::BITS_ERASE_FRAME) begin
                        reject_d = 1'b1;
                    end else if (!wel_q) begin
                        reject_d = 1'b1;
                    end else begin
                        page_d = addr_q[sfdpe_pkg::PAGE_MSB:sfdpe_pkg::PAGE_LSB];
                        start_d = 1'b1;
                        wel_d = 1'b0;
                        timer_d = TMR_W'(PageEraseCycles);
                        state_d = SFDPE_ERASING;
                    end
                end
            end
            SFDPE_ERASING: begin
                if (timer_q == TMR_W'(1)) begin
                    done_d = 1'b1;
                    state_d = SFDPE_IDLE;
                end else begin
                    timer_d = timer_q - TMR_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= SFDPE_IDLE;
            csSync_q <= 3'h7;
            csStable_q <= 1'b1;
            wel_q <= 1'b0;
            timer_q <= '0;
            page_q <= 11'h000;
            start_q <= 1'b0;
            done_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            state_q <= state_d;
            csSync_q <= {csSync_q[1:0], csN};
            csStable_q <= csStable_d;
            wel_q <= wel_d;
            timer_q <= timer_d;
            page_q <= page_d;
            start_q <= start_d;
            done_q <= done_d;
            reject_q <= reject_d;
        end
    end

    assign writeLatchFlag = wel_q;
    assign operationInProgressFlag = (state_q == SFDPE_ERASING);
    assign erasePageIndex = page_q;
    assign eraseStart = start_q;
    assign eraseDone = done_q;
    assign eraseRejected = reject_q;

    // ---------------- Quad read dummy clocks ----------------
    logic [3:0] dummy_q, dummy_d;
    logic [4:0] dataStart_q, dataStart_d;
    logic aligned_q, aligned_d;
    logic lastAligned_q, lastAligned_d;

    always_comb begin
        lastAligned_d = lastAligned_q;
        if (csRise && bitCnt_q >= sfdpe_pkg::BITS_CMD) begin
            if (opcode_q == sfdpe_pkg::OP_XIP_READ_ALIGNED) begin
                lastAligned_d = 1'b1;
            end else if (opcode_q == sfdpe_pkg::OP_XIP_READ) begin
                lastAligned_d = 1'b0;
            end
        end
        // Reserved settings above 100 are held at the largest count
        if (dummyCycleSetting > sfdpe_pkg::DC_MAX_SETTING) begin
            dummy_d = sfdpe_pkg::DC_MAX_CLOCKS;
        end else begin
            dummy_d = sfdpe_pkg::DC_BASE_CLOCKS + {dummyCycleSetting, 1'b0};
        end
        // Mode byte clocks sit inside the dummy count
        dataStart_d = sfdpe_pkg::XIP_CMD_CLOCKS + sfdpe_pkg::XIP_ADDR_CLOCKS +
                      {1'b0, dummy_d};
        aligned_d = lastAligned_d || dwordAlignSelect;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dummy_q <= sfdpe_pkg::DC_BASE_CLOCKS;
            dataStart_q <= 5'h10;
            aligned_q <= 1'b0;
            lastAligned_q <= 1'b0;
        end else begin
            dummy_q <= dummy_d;
            dataStart_q <= dataStart_d;
            aligned_q <= aligned_d;
            lastAligned_q <= lastAligned_d;
        end
    end

    assign xipDummyClocks = dummy_q;
    assign xipDataStartClock = dataStart_q;
    assign xipAlignedAddr = aligned_q;
endmodule

/* File: tb/sfdpe_core_properties.sv */
// Assertions on the ports of the flash command core
`timescale 1ns/1ps
module sfdpe_core_properties #(
    parameter int PageEraseCycles = 200
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic csN,
    input wire logic [2:0] dummyCycleSetting,
    input wire logic [3:0] xipDummyClocks,
    input wire logic [4:0] xipDataStartClock,
    input wire logic writeLatchFlag,
    input wire logic operationInProgressFlag,
    input wire logic eraseStart,
    input wire logic eraseDone,
    input wire logic eraseRejected
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [31:0] busyCnt_q;
    logic [31:0] busyCnt_d;
    always_comb busyCnt_d = operationInProgressFlag ? busyCnt_q + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) busyCnt_q <= 32'h0000_0000;
        else busyCnt_q <= busyCnt_d;
    end
    dummy_map_a: assert property (1 |=> xipDummyClocks == (($past(dummyCycleSetting) > 3'h4) ?
        4'hA : 4'h2 + {$past(dummyCycleSetting), 1'b0})) else $error("dummy count wrong");
    data_start_a: assert property (xipDataStartClock == 5'h0E + {1'b0, xipDummyClocks})
        else $error("data start clock wrong");
    start_busy_a: assert property (eraseStart |-> operationInProgressFlag && !writeLatchFlag)
        else $error("start without busy");
    busy_len_a: assert property (eraseDone |-> !operationInProgressFlag && busyCnt_q == PageEraseCycles)
        else $error("busy length wrong");
    busy_cause_a: assert property ($rose(operationInProgressFlag) |-> eraseStart)
        else $error("busy without start");
    reject_quiet_a: assert property (eraseRejected |-> !eraseStart && !operationInProgressFlag)
        else $error("rejected frame went busy");
    start_latch_a: assert property (eraseStart |-> $past(writeLatchFlag) && !$past(operationInProgressFlag))
        else $error("start without latch");
    start_cs_a: assert property (eraseStart |-> csN && $past(csN, 2))
        else $error("start with select low");
    cover property (eraseStart);
    cover property (eraseDone);
    cover property (eraseRejected);
endmodule
bind sfdpe_core sfdpe_core_properties #(.PageEraseCycles(PageEraseCycles)) u_props (
    .ref_clk(ref_clk), .reset_n(reset_n), .csN(csN), .dummyCycleSetting(dummyCycleSetting),
    .xipDummyClocks(xipDummyClocks), .xipDataStartClock(xipDataStartClock),
    .writeLatchFlag(writeLatchFlag), .operationInProgressFlag(operationInProgressFlag),
    .eraseStart(eraseStart), .eraseDone(eraseDone), .eraseRejected(eraseRejected));

/* File: tb/sfdpe_host_model.sv */
// Host serial controller model: chip select, link clock, serial input
`timescale 1ns/1ps
module sfdpe_host_model (
    output logic linkSck,
    output logic csN,
    output logic si,
    input wire logic so,
    input wire logic soOe
);
    logic soSeen;
    initial begin
        linkSck = 1'b0;
        csN = 1'b1;
        si = 1'b0;
    end
    // Plain frames at a slow clock, busy watched on the line
    task automatic frame(input logic [39:0] bits, input int n);
        soSeen = 1'bx;
        csN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = bits[i];
            #40 linkSck = 1'b1;
            #20 if (soOe === 1'b1) soSeen = so;
            #20 linkSck = 1'b0;
        end
        #40 csN = 1'b1;
        si = ~si;
    endtask
endmodule

/* File: tb/sfdpe_core_tb.sv */
// Self-checking bench for the flash command core
`timescale 1ns/1ps
module sfdpe_core_tb;
    localparam logic [23:0] Addr = 24'hFA_B75C;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic linkSck, csN, si, so, soOe, xipAlignedAddr, writeLatchFlag, operationInProgressFlag;
    logic eraseStart, eraseDone, eraseRejected, sawStart, sawDone, sawRej;
    logic [2:0] dummyCycleSetting = 3'h0;
    logic dwordAlignSelect = 1'b0;
    logic [3:0] xipDummyClocks;
    logic [4:0] xipDataStartClock;
    logic [10:0] erasePageIndex;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    sfdpe_core #(.PageEraseCycles(200)) u_sfdpe_core (.ref_clk(ref_clk), .reset_n(reset_n),
        .linkSck(linkSck), .csN(csN), .si(si), .so(so), .soOe(soOe),
        .dummyCycleSetting(dummyCycleSetting), .dwordAlignSelect(dwordAlignSelect),
        .xipDummyClocks(xipDummyClocks), .xipDataStartClock(xipDataStartClock),
        .xipAlignedAddr(xipAlignedAddr), .writeLatchFlag(writeLatchFlag),
        .operationInProgressFlag(operationInProgressFlag), .erasePageIndex(erasePageIndex),
        .eraseStart(eraseStart), .eraseDone(eraseDone), .eraseRejected(eraseRejected));
    sfdpe_host_model u_sfdpe_host_model (.linkSck(linkSck), .csN(csN), .si(si), .so(so),
        .soOe(soOe));
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (eraseStart === 1'b1) sawStart <= 1'b1;
        if (eraseDone === 1'b1) sawDone <= 1'b1;
        if (eraseRejected === 1'b1) sawRej <= 1'b1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic send(input logic [39:0] bits, input int n);
        @(negedge ref_clk);
        {sawStart, sawDone, sawRej} = 3'h0;
        u_sfdpe_host_model.frame(bits, n);
        repeat (8) @(negedge ref_clk);
    endtask
    task automatic dummy_table();
        int d;
        for (int s = 0; s < 16; s++) begin
            @(negedge ref_clk);
            dummyCycleSetting = s[2:0];
            dwordAlignSelect = s[3];
            repeat (2) @(negedge ref_clk);
            d = (s % 8 > 4) ? 10 : 2 + 2 * (s % 8);
            check(11'(xipDummyClocks), 11'(d));
            check(11'(xipDataStartClock), 11'(d + 14));
            check(11'(xipAlignedAddr), 11'(s[3]));
        end
        dwordAlignSelect = 1'b0;
        send(40'h00_0000_00E7, 8);
        check(11'(xipAlignedAddr), 11'h001);
        send(40'h00_0000_00EB, 8);
        check(11'(xipAlignedAddr), 11'h000);
    endtask
    task automatic refused();
        send({8'h00, 8'h81, Addr}, 32);
        check(11'({sawRej, sawStart, operationInProgressFlag}), 11'h004);
        for (int k = 0; k < 2; k++) begin
            send(40'h00_0000_0006, 8);
            send({8'h00, 8'h81, Addr} >> (4 + 4 * k), 28 - 4 * k);
            check(11'({sawRej, sawStart, operationInProgressFlag}), 11'h004);
        end
    endtask
    task automatic erase_run();
        send(40'h00_0000_0006, 8);
        check(11'(writeLatchFlag), 11'h001);
        send({8'h00, 8'hDB, Addr}, 32);
        check(11'({sawStart, operationInProgressFlag, writeLatchFlag}), 11'h006);
        check(erasePageIndex, Addr[18:8]);
        send(40'h00_0000_2500, 16);
        check(11'(u_sfdpe_host_model.soSeen), 11'h001);
        for (int i = 0; i < 400 && !sawDone; i++) @(negedge ref_clk);
        check(11'({sawDone, operationInProgressFlag}), 11'h002);
        send(40'h00_0000_2500, 16);
        check(11'(u_sfdpe_host_model.soSeen), 11'h000);
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        dummy_table();
        refused();
        erase_run();
        wrap_up();
    end
endmodule
